// file: hdl/cmw_defines.vh
// Constants for the transceiver mode and wake logic.
`ifndef CMW_DEFINES_VH
`define CMW_DEFINES_VH
`define CMW_CLK_PERIOD_PS 5000
`define CMW_DTO_TIME_US 1200
`define CMW_DTO_CYCLES ((`CMW_DTO_TIME_US * 1000000) / `CMW_CLK_PERIOD_PS)
`define CMW_WK_FILTER_NS 900
`define CMW_WK_FILTER_CYCLES ((`CMW_WK_FILTER_NS * 1000) / `CMW_CLK_PERIOD_PS)
`define CMW_WK_TIMEOUT_US 1800
`define CMW_WK_TIMEOUT_CYCLES ((`CMW_WK_TIMEOUT_US * 1000000) / `CMW_CLK_PERIOD_PS)
`define CMW_FIFO_DEPTH 8
`define CMW_FIFO_WIDTH 1
`endif

// file: hdl/cmw_sync2.v
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/10ps
`default_nettype none
module cmw_sync2
#(
	parameter RESET_VALUE = 1'b1
)
(
	input  wire core_clk,
	input  wire sys_rst,
	input  wire clkEn,
	input  wire asyncIn,
	output wire syncOut
);
	reg firstStage_reg;
	reg secondStage_reg;

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			firstStage_reg <= RESET_VALUE;
			secondStage_reg <= RESET_VALUE;
		end
		else if (clkEn)
		begin
			firstStage_reg <= asyncIn;
			secondStage_reg <= firstStage_reg;
		end
	end

	assign syncOut = secondStage_reg;
endmodule
`default_nettype wire

// file: hdl/cmw_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module cmw_fifo
#(
	parameter WIDTH = 1,
	parameter DEPTH = 8,
	parameter AW    = 3
)
(
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire             clkEn,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_reg;
	reg [AW-1:0]    rdPtr_reg;
	reg [AW:0]      count_reg;
	wire            doWrite;
	wire            doRead;

	assign inReady = (count_reg != DEPTH[AW:0]);
	assign outValid = (count_reg != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_reg];
	assign doWrite = inValid & inReady & clkEn;
	assign doRead = outValid & outReady & clkEn;

	always @(posedge core_clk)
	begin
		if (doWrite)
			mem[wrPtr_reg] <= inData;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (doWrite)
				wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wrPtr_reg + 1'b1;
			if (doRead)
				rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rdPtr_reg + 1'b1;
			if (doWrite & ~doRead)
				count_reg <= count_reg + 1'b1;
			else if (doRead & ~doWrite)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: hdl/cmw_transceiver_logic.v
// Mode control, dominant timeout and remote wake logic of a CAN transceiver.
`include "cmw_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module cmw_transceiver_logic
#(
	parameter DTO_CYCLES     = `CMW_DTO_CYCLES,
	parameter FILTER_CYCLES  = `CMW_WK_FILTER_CYCLES,
	parameter TIMEOUT_CYCLES = `CMW_WK_TIMEOUT_CYCLES,
	parameter CW             = 20,
	parameter FIFO_DEPTH     = `CMW_FIFO_DEPTH
)
(
	input  wire core_clk,
	input  wire sys_rst,
	input  wire clkEn,
	input  wire txdIn,
	input  wire txdDriven,
	input  wire modeSelectIn,
	input  wire modeSelectDriven,
	input  wire busDominantIn,
	output reg  rxdOut,
	output reg  busDriveDominant,
	output reg  busBiasRecessive,
	output reg  busPullGround,
	output reg  standbyActive,
	output reg  dominantTimeoutFault,
	output reg  wakeRecognised
);
	localparam [3:0] WK_IDLE = 4'h1;
	localparam [3:0] WK_WAIT_REC = 4'h2;
	localparam [3:0] WK_WAIT_DOM = 4'h4;
	localparam [3:0] WK_AWAKE = 4'h8;

	// Positions of the pins in the synchroniser bank.
	localparam integer PIN_TXD = 0;
	localparam integer PIN_TXD_ON = 1;
	localparam integer PIN_MODE = 2;
	localparam integer PIN_MODE_ON = 3;
	localparam integer PIN_BUS = 4;
	localparam integer PIN_COUNT = 5;
	// Reset levels: pins idle at their bias, the bus recessive.
	localparam [4:0] SYNC_RESET = 5'h0f;

	wire [PIN_COUNT-1:0] pinRaw;
	wire [PIN_COUNT-1:0] pinSync;
	wire                 txdSync;
	wire                 modeSelectSync;
	wire                 busDomSync;

	assign pinRaw[PIN_TXD] = txdIn;
	assign pinRaw[PIN_TXD_ON] = txdDriven;
	assign pinRaw[PIN_MODE] = modeSelectIn;
	assign pinRaw[PIN_MODE_ON] = modeSelectDriven;
	assign pinRaw[PIN_BUS] = busDominantIn;

	// Every pin passes two flops before any logic reads it.
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1)
		begin : gSync
			cmw_sync2 #(.RESET_VALUE(SYNC_RESET[g])) uSync
			(
				.core_clk (core_clk),
				.sys_rst  (sys_rst),
				.clkEn    (clkEn),
				.asyncIn  (pinRaw[g]),
				.syncOut  (pinSync[g])
			);
		end
	endgenerate

	// Undriven inputs fall back to their weak-bias level. Level and
	// drive flag are synchronised apart, so a pin that floats at the
	// same time as it changes level may show one stale cycle.
	assign txdSync = pinSync[PIN_TXD_ON] ?
		pinSync[PIN_TXD] : 1'b1;
	assign modeSelectSync = pinSync[PIN_MODE_ON] ?
		pinSync[PIN_MODE] : 1'b1;
	assign busDomSync = pinSync[PIN_BUS];

	// Dominant timeout: the counter starts on a falling transmit edge.
	reg  [CW-1:0] dtoCount_reg;
	reg           dtoFault_reg;
	reg           txdPrev_reg;
	wire          dtoClear;
	wire          dtoExpired;

	// Recessive input or standby clears both counter and fault.
	assign dtoClear = modeSelectSync | txdSync;
	assign dtoExpired = (dtoCount_reg >= DTO_CYCLES[CW-1:0]);

	always @(posedge core_clk)
	begin
		if (sys_rst)
			txdPrev_reg <= 1'b1;
		else if (clkEn)
			txdPrev_reg <= txdSync;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			dtoCount_reg <= {CW{1'b0}};
		else if (clkEn)
		begin
			if (dtoClear)
				dtoCount_reg <= {CW{1'b0}};
			else if (txdPrev_reg)
				dtoCount_reg <= {{(CW-1){1'b0}}, 1'b1};
			else if (~dtoExpired)
				dtoCount_reg <= dtoCount_reg + 1'b1;
		end
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			dtoFault_reg <= 1'b0;
		else if (clkEn)
		begin
			if (dtoClear)
				dtoFault_reg <= 1'b0;
			else if (~txdPrev_reg & dtoExpired)
				dtoFault_reg <= 1'b1;
		end
	end

	// Bus state filter: a state counts once it outlasts the filter time.
	reg  [CW-1:0] filtCount_reg;
	reg           filtLevel_reg;
	reg           busPrev_reg;
	reg           filtDomPulse;
	reg           filtRecPulse;
	wire          filtDone;
	wire          filtChange;

	assign filtDone = (filtCount_reg >= FILTER_CYCLES[CW-1:0]);
	assign filtChange = filtDone & (busDomSync == busPrev_reg)
		& (filtLevel_reg != busDomSync);

	always @(posedge core_clk)
	begin
		if (sys_rst)
			busPrev_reg <= 1'b0;
		else if (clkEn)
			busPrev_reg <= busDomSync;
	end

	// Any edge restarts the count, so short glitches never qualify.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			filtCount_reg <= {CW{1'b0}};
		else if (clkEn)
		begin
			if (busDomSync != busPrev_reg)
				filtCount_reg <= {CW{1'b0}};
			else if (~filtDone)
				filtCount_reg <= filtCount_reg + 1'b1;
		end
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			filtLevel_reg <= 1'b0;
		else if (clkEn & filtChange)
			filtLevel_reg <= busDomSync;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			filtDomPulse <= 1'b0;
			filtRecPulse <= 1'b0;
		end
		else if (clkEn)
		begin
			filtDomPulse <= filtChange & busDomSync;
			filtRecPulse <= filtChange & ~busDomSync;
		end
	end

	// Wake monitor.
	reg [3:0]    wkState_reg;
	reg [3:0]    wkState_next;
	reg [CW-1:0] wkTimer_reg;
	wire         wkTimeout;
	wire         wkTimerRun;

	// A pattern that ends on the timeout cycle itself is dropped.
	assign wkTimeout = (wkTimer_reg >= TIMEOUT_CYCLES[CW-1:0]);
	assign wkTimerRun = (wkState_next == WK_WAIT_REC)
		| (wkState_next == WK_WAIT_DOM);

	always @*
	begin
		wkState_next = wkState_reg;
		case (wkState_reg)
			WK_IDLE:
				if (filtDomPulse)
					wkState_next = WK_WAIT_REC;
			WK_WAIT_REC:
				if (wkTimeout)
					wkState_next = WK_IDLE;
				else if (filtRecPulse)
					wkState_next = WK_WAIT_DOM;
			WK_WAIT_DOM:
				if (wkTimeout)
					wkState_next = WK_IDLE;
				else if (filtDomPulse)
					wkState_next = WK_AWAKE;
			WK_AWAKE:
				wkState_next = WK_AWAKE;
			default:
				wkState_next = WK_IDLE;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			wkState_reg <= WK_IDLE;
		else if (clkEn)
		begin
			if (~modeSelectSync)
				wkState_reg <= WK_IDLE;
			else
				wkState_reg <= wkState_next;
		end
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			wkTimer_reg <= {CW{1'b0}};
		else if (clkEn)
		begin
			if (~modeSelectSync)
				wkTimer_reg <= {CW{1'b0}};
			else if (wkTimerRun)
				wkTimer_reg <= wkTimer_reg + 1'b1;
			else
				wkTimer_reg <= {CW{1'b0}};
		end
	end

	// Receive stream buffer. The FIFO gives the receive path a fixed
	// latency in both modes; it is read every cycle, so it never fills.
	reg  rxdLevel;
	wire fifoOutData;
	wire fifoOutValid;

	always @*
	begin
		if (~modeSelectSync)
			rxdLevel = ~busDomSync;
		else if (wkState_reg == WK_AWAKE)
			rxdLevel = ~filtLevel_reg;
		else
			rxdLevel = 1'b1;
	end

	cmw_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH), .AW(3)) uRxFifo
	(
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.inData   (rxdLevel),
		.inValid  (1'b1),
		.inReady  (),
		.outData  (fifoOutData),
		.outValid (fifoOutValid),
		.outReady (1'b1)
	);

	// Output registers: every port comes straight from a flop.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			rxdOut <= 1'b1;
		else if (clkEn & fifoOutValid)
			rxdOut <= fifoOutData;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			standbyActive <= 1'b1;
		else if (clkEn)
			standbyActive <= modeSelectSync;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			busPullGround <= 1'b1;
		else if (clkEn)
			busPullGround <= modeSelectSync;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			busBiasRecessive <= 1'b0;
		else if (clkEn)
			busBiasRecessive <= ~modeSelectSync;
	end

	// The driver is gated by mode and by the dominant timeout fault.
	always @(posedge core_clk)
	begin
		if (sys_rst)
			busDriveDominant <= 1'b0;
		else if (clkEn)
			busDriveDominant <= ~modeSelectSync & ~txdSync
				& ~dtoFault_reg;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			dominantTimeoutFault <= 1'b0;
		else if (clkEn)
			dominantTimeoutFault <= dtoFault_reg;
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
			wakeRecognised <= 1'b0;
		else if (clkEn)
			wakeRecognised <= (wkState_reg == WK_AWAKE);
	end
endmodule
`default_nettype wire

// file: tb/cmw_monitor.sv
// Checker for the transceiver mode and wake logic.
`timescale 1ns/10ps
`default_nettype none
module cmw_monitor
#(
	parameter DTO_CYCLES = 50
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic txdIn,
	input wire logic txdDriven,
	input wire logic modeSelectIn,
	input wire logic modeSelectDriven,
	input wire logic rxdOut,
	input wire logic busDriveDominant,
	input wire logic busBiasRecessive,
	input wire logic busPullGround,
	input wire logic standbyActive,
	input wire logic dominantTimeoutFault,
	input wire logic wakeRecognised
);
	wire        hi     = modeSelectIn | ~modeSelectDriven;
	wire        txL    = ~txdIn & txdDriven & ~hi;
	int         domCnt = 0;
	logic [4:0] stbCnt = 5'h00;
	// Slack of a few cycles covers the input synchronisers.
	always @(posedge core_clk)
	begin
		domCnt <= (sys_rst || !txL) ? 0 : domCnt + 1;
		if (sys_rst || !standbyActive || wakeRecognised)
			stbCnt <= 5'h00;
		else if (stbCnt != 5'h1f)
			stbCnt <= stbCnt + 5'h01;
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence sHi;
		hi [*5];
	endsequence
	sequence sLo;
		(!hi) [*5];
	endsequence
	sequence sTxL;
		txL [*5] ##0 (!standbyActive && !dominantTimeoutFault);
	endsequence
	AST_MODE_HI: assert property (sHi |-> standbyActive)
		else $error("standby expected");
	AST_MODE_LO: assert property (sLo |-> !standbyActive)
		else $error("normal mode expected");
	AST_STBY_BUS: assert property (standbyActive |->
		busPullGround && !busBiasRecessive && !busDriveDominant)
		else $error("standby bus state wrong");
	AST_NORM_BUS: assert property (!standbyActive |->
		busBiasRecessive && !busPullGround)
		else $error("normal bias wrong");
	AST_TX_DOM: assert property (sTxL |-> busDriveDominant)
		else $error("dominant not driven");
	AST_TX_REC: assert property ((txdIn | ~txdDriven) [*5] |->
		!busDriveDominant && !dominantTimeoutFault)
		else $error("recessive not kept");
	AST_DTO: assert property (domCnt == DTO_CYCLES + 8 |->
		dominantTimeoutFault && !busDriveDominant)
		else $error("dominant timeout missing");
	AST_WAKE_CLR: assert property (sLo |-> !wakeRecognised)
		else $error("wake state not cleared");
	AST_STBY_RXD: assert property (stbCnt > 5'h14 |-> rxdOut)
		else $error("receive output low in standby");
endmodule
bind cmw_transceiver_logic cmw_monitor #(.DTO_CYCLES(DTO_CYCLES)) cmw_monitor_i
(
	.core_clk(core_clk), .sys_rst(sys_rst), .txdIn(txdIn),
	.txdDriven(txdDriven), .modeSelectIn(modeSelectIn),
	.modeSelectDriven(modeSelectDriven), .rxdOut(rxdOut),
	.busDriveDominant(busDriveDominant),
	.busBiasRecessive(busBiasRecessive), .busPullGround(busPullGround),
	.standbyActive(standbyActive),
	.dominantTimeoutFault(dominantTimeoutFault),
	.wakeRecognised(wakeRecognised)
);
`default_nettype wire

// file: tb/cmw_host_model.sv
// Model of the host controller that drives transmit and mode select.
`timescale 1ns/10ps
`default_nettype none
module cmw_host_model
(
	input  wire logic core_clk,
	input  wire logic txReq,
	input  wire logic txFloat,
	input  wire logic modeReq,
	input  wire logic modeFloat,
	input  wire logic rxdOut,
	output wire logic txdIn,
	output wire logic txdDriven,
	output wire logic modeSelectIn,
	output wire logic modeSelectDriven
);
	logic rxdPrev_reg = 1'b1;
	logic woke_reg    = 1'b0;
	// A floating pin shows the level of its pull-up.
	assign txdIn            = txFloat | txReq;
	assign txdDriven        = ~txFloat;
	assign modeSelectIn     = modeFloat | (modeReq & ~woke_reg);
	assign modeSelectDriven = ~modeFloat;
	always @(negedge core_clk)
	begin
		rxdPrev_reg <= rxdOut;
		if (!modeReq)
			woke_reg <= 1'b0;
		else if (rxdPrev_reg && !rxdOut)
			woke_reg <= 1'b1;
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the transceiver mode and wake logic.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        core_clk  = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        busDom    = 1'b0;
	logic        txReq     = 1'b1;
	logic        txFloat   = 1'b0;
	logic        modeReq   = 1'b1;
	logic        modeFloat = 1'b1;
	logic [31:0] seed      = 32'h0000000d;
	int          errorCnt  = 0;
	int          nTests    = 0;
	int          i;
	wire txd, txdOn, mode, modeOn, rxd, drv, bias, pull, stb, flt, wake;
	cmw_host_model cmw_host_model_i (.core_clk(core_clk), .txReq(txReq),
		.txFloat(txFloat), .modeReq(modeReq), .modeFloat(modeFloat),
		.rxdOut(rxd), .txdIn(txd), .txdDriven(txdOn),
		.modeSelectIn(mode), .modeSelectDriven(modeOn));
	// Short counts keep the run brief; expectations follow them.
	cmw_transceiver_logic #(.DTO_CYCLES(50), .FILTER_CYCLES(10),
		.TIMEOUT_CYCLES(300)) cmw_transceiver_logic_i (.core_clk(core_clk),
		.sys_rst(sys_rst), .clkEn(1'b1), .txdIn(txd), .txdDriven(txdOn),
		.modeSelectIn(mode), .modeSelectDriven(modeOn),
		.busDominantIn(busDom), .rxdOut(rxd), .busDriveDominant(drv),
		.busBiasRecessive(bias), .busPullGround(pull),
		.standbyActive(stb), .dominantTimeoutFault(flt),
		.wakeRecognised(wake));
	always #2.5 core_clk = ~core_clk;
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic expDrive(input logic tx, input logic fl);
		return ~(tx | fl);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic bus(input logic v, input int n);
		busDom = v;
		cyc(n);
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		nTests++;
		if (g !== e)
		begin
			$display("wrong value %s expected %b seen %b", nm, e, g);
			errorCnt++;
		end
	endtask
	task reportAndStop;
		$display("checks %0d errors %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#25000;
		errorCnt++;
		reportAndStop;
	end
	initial
	begin
		cyc(3);
		sys_rst = 1'b0;
		cyc(6);
		chk("standby", 1'b1, stb);
		chk("pull", 1'b1, pull);
		modeFloat = 1'b0;
		modeReq = 1'b0;
		cyc(6);
		chk("standby", 1'b0, stb);
		for (i = 0; i < 24; i++)
		begin
			seed = xorshift(seed);
			txReq = seed[0];
			txFloat = seed[1] & seed[2];
			busDom = seed[3];
			cyc(24);
			chk("drive", expDrive(txReq, txFloat), drv);
			chk("rxd", ~busDom, rxd);
			txReq = 1'b1;
			cyc(3);
		end
		txFloat = 1'b0;
		busDom = 1'b0;
		txReq = 1'b0;
		cyc(70);
		chk("fault", 1'b1, flt);
		txReq = 1'b1;
		cyc(6);
		chk("fault", 1'b0, flt);
		modeReq = 1'b1;
		cyc(6);
		txReq = 1'b0;
		cyc(6);
		chk("drive", 1'b0, drv);
		txReq = 1'b1;
		bus(1'b1, 5);
		bus(1'b0, 5);
		bus(1'b1, 5);
		bus(1'b0, 20);
		chk("wake", 1'b0, wake);
		bus(1'b1, 15);
		bus(1'b0, 3);
		bus(1'b1, 5);
		bus(1'b0, 15);
		bus(1'b1, 3);
		bus(1'b0, 5);
		bus(1'b1, 18);
		chk("wake", 1'b1, wake);
		for (i = 0; i < 40 && rxd !== 1'b0; i++)
			cyc(1);
		chk("rxd", 1'b0, rxd);
		bus(1'b0, 12);
		chk("standby", 1'b0, stb);
		chk("wake", 1'b0, wake);
		modeReq = 1'b0;
		cyc(2);
		modeReq = 1'b1;
		cyc(8);
		bus(1'b1, 16);
		bus(1'b0, 400);
		bus(1'b1, 16);
		bus(1'b0, 20);
		chk("wake", 1'b0, wake);
		reportAndStop;
	end
endmodule
`default_nettype wire
